//--- design/dssp_pkg.sv
package dssp_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] SP_ADDR    = 8'h81;
  localparam logic [7:0] PAGE_ADDR  = 8'h84;
  localparam logic [7:0] MID_ADDR   = 8'h85;
  localparam logic [7:0] BOT_ADDR   = 8'h86;
  localparam logic [7:0] PGCN_ADDR  = 8'h96;
  localparam logic [7:0] CBANK_ADDR = 8'hb1;
  localparam logic [7:0] PSW_ADDR   = 8'hd0;

  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [7:0] SP_RST     = 8'h07;
  localparam logic [7:0] PGCN_RST   = 8'h01;
  localparam logic [7:0] CBANK_RST  = 8'h11;
  localparam logic [7:0] PSW_RST    = 8'h00;
  localparam logic [7:0] PAGE_RST   = 8'h00;
  localparam int         RS_LSB     = 3;
  localparam int         PGEN_BIT   = 0;
  localparam int         IFB_LSB    = 0;
  localparam logic [3:0] BIT_AREA_HI = 4'h2;

  // ----------------------------------------
  // Pages and all-page ports
  // ----------------------------------------
  localparam logic [7:0] PAGE_F     = 8'h0f;
  localparam logic [7:0] PORT0_ADDR = 8'h80;
  localparam logic [7:0] PORT1_ADDR = 8'h90;
  localparam logic [7:0] PORT2_ADDR = 8'ha0;
  localparam logic [7:0] PORT3_ADDR = 8'hb0;

  typedef enum logic [2:0] {
    STK_NONE = 3'h0,
    STK_PUSH = 3'h1,
    STK_POP  = 3'h2,
    STK_INC  = 3'h3,
    STK_DEC  = 3'h4,
    STK_CALL = 3'h5,
    STK_RET  = 3'h6
  } dssp_stk_e;

  typedef struct packed {
    logic       valid;
    logic       wr;
    logic       indirect;
    logic       is_bit;
    logic       ind_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dssp_acc_s;

  typedef struct packed {
    logic       valid;
    logic       wr;
    logic       is_bit;
    logic       all_page;
    logic       page_ok;
    logic [7:0] page;
    logic [7:0] addr;
    logic [2:0] bitpos;
    logic [7:0] wdata;
  } dssp_sfr_s;

endpackage : dssp_pkg

//--- design/dssp_core.sv
// Operation
// R1: 256 byte internal RAM, 0x00 to 0xFF
// R2: Lower 128 bytes reachable direct or indirect
// R3: Four register banks chosen by status bits
// R4: Upper direct goes SFR, indirect goes RAM
// R5: Indirect pointer from index reg zero/one
// R6: Bytes 0x20-0x2F form 128 bits
// R7: Bit or byte chosen by operand type
// R8: Push writes above pointer, then increments
// R9: Stack pointer resets to 0x07
// R10: Record shifts per push, call, pop, return
// R11: Record overflow and underflow flagged to debug
// R12: Bit access only at nibble 0 or 8
// R13: Software avoids unoccupied SFR addresses
// R14: 256 pages, populated 0,1,2,3,F
// R15: All-page registers ignore page select
// R16: Interrupt loads page of its flag
// R17: Interrupt entry pushes three-entry page stack
// R18: Return pops stack, empty bottom yields zero
// R19: Software stack writes never push or pop
// R20: Auto-page enable bit set after reset
// R21: Software selects page before direct access
// R22: Low fetches bank 0, high fetch bank field
// R23: Fetch bank field picks upper code bank
// R24: Auto-page disabled means no switch or shift
// R25: Entry push overwrites software bottom value
// R26: Bottom entry cleared after each pop
module dssp_core
  import dssp_pkg::*;
#(
  parameter int REC_W = 32
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire dssp_acc_s   acc,
  input  wire dssp_stk_e   stk_op,
  input  wire logic [15:0] stk_wdata,
  input  wire logic        irq_enter,
  input  wire logic [7:0]  irq_page,
  input  wire logic        irq_return,
  input  wire logic [15:0] fetch_addr,
  input  wire logic [7:0]  sfr_rdata,
  input  wire logic        dbg_clr,
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  output dssp_sfr_s        sfr_req,
  output logic [16:0]      fetch_phys,
  output logic [7:0]       stack_pointer,
  output logic [7:0]       page_select_reg,
  output logic [REC_W-1:0] stack_record,
  output logic             dbg_ovf,
  output logic             dbg_unf
);

  if (REC_W < 2 || REC_W > 62) begin : g_rec_w_check
    $error("REC_W out of range");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0]       ram [256];
  logic [7:0]       sp_q, sp_d, psw_q, psw_d, cbank_q, cbank_d;
  logic [7:0]       page_q, page_d, mid_q, mid_d, bot_q, bot_d;
  logic             pgen_q, pgen_d;
  logic [REC_W-1:0] rec_q, rec_d;
  logic [5:0]       cnt_q, cnt_d;
  logic             ovf_q, ovf_d, unf_q, unf_d;
  logic [15:0]      rd_q, rd_d;
  logic             rdv_q, rdv_d;
  logic             we0, we1;
  logic [7:0]       wa0, wa1, wd0, wd1;
  logic [7:0]       ptr, ea, bval, nval;
  logic [2:0]       bp;
  logic             to_sfr, int_hit, acc_wr, auto_push, auto_pop, sw_pg_wr;
  logic [5:0]       full;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb begin
    ptr = ram[{3'h0, psw_q[RS_LSB+1:RS_LSB], 2'h0, acc.ind_sel}];  // [R3] [R5]
    bp  = acc.addr[2:0];
    if (acc.is_bit) begin  // [R7]
      if (!acc.addr[7]) ea = {BIT_AREA_HI, acc.addr[6:3]};  // [R6]
      else ea = {acc.addr[7:3], 3'h0};  // [R12]
    end else if (acc.indirect) begin
      ea = ptr;  // [R2] [R4]
    end else begin
      ea = acc.addr;
    end
    to_sfr  = !acc.indirect && ea[7];  // [R4]
    int_hit = to_sfr && (ea == SP_ADDR || ea == PSW_ADDR || ea == PAGE_ADDR || ea == MID_ADDR
              || ea == BOT_ADDR || ea == PGCN_ADDR || ea == CBANK_ADDR);
    case (ea)
      SP_ADDR:    bval = sp_q;
      PSW_ADDR:   bval = psw_q;
      PAGE_ADDR:  bval = page_q;
      MID_ADDR:   bval = mid_q;
      BOT_ADDR:   bval = bot_q;
      PGCN_ADDR:  bval = {7'h00, pgen_q};
      CBANK_ADDR: bval = cbank_q;
      default:    bval = to_sfr ? sfr_rdata : ram[ea];  // [R1]
    endcase
    if (!to_sfr) bval = ram[ea];
    nval = acc.wdata;
    if (acc.is_bit) begin
      nval     = bval;
      nval[bp] = acc.wdata[0];
    end
    acc_wr = acc.valid && acc.wr && stk_op == STK_NONE;
  end

  // ----------------------------------------
  // Peripheral SFR request
  // ----------------------------------------
  always_comb begin
    sfr_req          = '0;
    sfr_req.valid    = acc.valid && to_sfr && !int_hit;
    sfr_req.wr       = acc_wr;
    sfr_req.is_bit   = acc.is_bit;  // [R12]
    sfr_req.page     = page_q;  // [R14]
    sfr_req.page_ok  = page_q[7:2] == 6'h00 || page_q == PAGE_F;  // [R14]
    sfr_req.all_page = ea == PORT0_ADDR || ea == PORT1_ADDR || ea == PORT2_ADDR
                       || ea == PORT3_ADDR;  // [R15]
    sfr_req.addr     = ea;
    sfr_req.bitpos   = bp;
    sfr_req.wdata    = nval;
  end

  // ----------------------------------------
  // Stack, record and registers
  // ----------------------------------------
  always_comb begin
    sp_d    = sp_q;
    psw_d   = psw_q;
    cbank_d = cbank_q;
    pgen_d  = pgen_q;
    rec_d   = rec_q;
    cnt_d   = cnt_q;
    ovf_d   = ovf_q && !dbg_clr;
    unf_d   = unf_q && !dbg_clr;
    rd_d    = rd_q;
    rdv_d   = 1'b0;
    we0     = 1'b0;
    we1     = 1'b0;
    wa0     = sp_q + 8'h01;
    wa1     = sp_q + 8'h02;
    wd0     = stk_wdata[7:0];
    wd1     = stk_wdata[15:8];
    full    = 6'(REC_W);
    case (stk_op)
      STK_PUSH, STK_INC: begin
        we0   = stk_op == STK_PUSH;  // [R8]
        sp_d  = sp_q + 8'h01;  // [R8]
        rec_d = {rec_q[REC_W-2:0], 1'b0};  // [R10]
        if (cnt_q == full) ovf_d = 1'b1;  // [R11]
        else cnt_d = cnt_q + 6'h01;
      end
      STK_CALL: begin
        we0   = 1'b1;
        we1   = 1'b1;
        sp_d  = sp_q + 8'h02;
        rec_d = {rec_q[REC_W-3:0], 2'b11};  // [R10]
        if (cnt_q > full - 6'h02) begin
          ovf_d = 1'b1;  // [R11]
          cnt_d = full;
        end else begin
          cnt_d = cnt_q + 6'h02;
        end
      end
      STK_POP, STK_DEC: begin
        sp_d  = sp_q - 8'h01;
        rec_d = {1'b0, rec_q[REC_W-1:1]};  // [R10]
        rd_d  = {8'h00, ram[sp_q]};
        rdv_d = stk_op == STK_POP;
        if (cnt_q == 6'h00) unf_d = 1'b1;  // [R11]
        else cnt_d = cnt_q - 6'h01;
      end
      STK_RET: begin
        sp_d  = sp_q - 8'h02;
        rec_d = {2'b00, rec_q[REC_W-1:2]};  // [R10]
        rd_d  = {ram[sp_q], ram[sp_q - 8'h01]};
        rdv_d = 1'b1;
        if (cnt_q < 6'h02) begin
          unf_d = 1'b1;  // [R11]
          cnt_d = 6'h00;
        end else begin
          cnt_d = cnt_q - 6'h02;
        end
      end
      default: begin
        if (acc.valid && !acc.wr) begin
          rdv_d = 1'b1;
          rd_d  = {8'h00, acc.is_bit ? {7'h00, bval[bp]} : bval};
          if (sfr_req.valid && acc.is_bit) rd_d = {15'h0000, sfr_rdata[bp]};
        end
        if (acc_wr && !to_sfr) begin
          we0 = 1'b1;  // [R2] [R4]
          wa0 = ea;
          wd0 = nval;
        end
        if (acc_wr && int_hit) begin
          case (ea)
            SP_ADDR:    sp_d = nval;
            PSW_ADDR:   psw_d = nval;  // [R3]
            PGCN_ADDR:  pgen_d = nval[PGEN_BIT];  // [R20]
            CBANK_ADDR: cbank_d = nval;  // [R23]
            default:    ;
          endcase
        end
      end
    endcase
  end

  // ----------------------------------------
  // Page stack
  // ----------------------------------------
  always_comb begin
    page_d    = page_q;
    mid_d     = mid_q;
    bot_d     = bot_q;
    sw_pg_wr  = acc_wr && to_sfr && (ea == PAGE_ADDR || ea == MID_ADDR || ea == BOT_ADDR);
    auto_push = irq_enter && pgen_q;  // [R24]
    auto_pop  = irq_return && pgen_q && !irq_enter;  // [R24]
    if (sw_pg_wr) begin
      case (ea)
        PAGE_ADDR: page_d = nval;  // [R19] [R21]
        MID_ADDR:  mid_d = nval;  // [R19]
        default:   bot_d = nval;  // [R19]
      endcase
    end
    if (auto_push) begin
      bot_d  = mid_q;  // [R17] [R25]
      mid_d  = page_q;  // [R17]
      page_d = irq_page;  // [R16]
    end else if (auto_pop) begin
      page_d = mid_q;  // [R18]
      mid_d  = bot_q;  // [R18]
      bot_d  = 8'h00;  // [R26]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sp_q    <= SP_RST;  // [R9]
      psw_q   <= PSW_RST;
      cbank_q <= CBANK_RST;
      pgen_q  <= PGCN_RST[PGEN_BIT];  // [R20]
      page_q  <= PAGE_RST;
      mid_q   <= 8'h00;
      bot_q   <= 8'h00;
      rec_q   <= '0;
      cnt_q   <= 6'h00;
      ovf_q   <= 1'b0;
      unf_q   <= 1'b0;
      rd_q    <= 16'h0000;
      rdv_q   <= 1'b0;
    end else begin
      sp_q    <= sp_d;
      psw_q   <= psw_d;
      cbank_q <= cbank_d;
      pgen_q  <= pgen_d;
      page_q  <= page_d;
      mid_q   <= mid_d;
      bot_q   <= bot_d;
      rec_q   <= rec_d;
      cnt_q   <= cnt_d;
      ovf_q   <= ovf_d;
      unf_q   <= unf_d;
      rd_q    <= rd_d;
      rdv_q   <= rdv_d;
    end
  end

  // ----------------------------------------
  // RAM write ports
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (we0) ram[wa0] <= wd0;  // [R1] [R8]
    if (we1) ram[wa1] <= wd1;
  end

  // ----------------------------------------
  // Outputs and code fetch
  // ----------------------------------------
  assign fetch_phys      = {fetch_addr[15] ? cbank_q[IFB_LSB+1:IFB_LSB] : 2'b00, fetch_addr[14:0]};  // [R22] [R23]
  assign rd_data         = rd_q;
  assign rd_valid        = rdv_q;
  assign stack_pointer   = sp_q;
  assign page_select_reg = page_q;
  assign stack_record    = rec_q;
  assign dbg_ovf         = ovf_q;
  assign dbg_unf         = unf_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_sp_after_reset: assert property ($past(rst) && !rst |-> sp_q == SP_RST)  // [R9]
    else $error("stack pointer not at reset value");
  a_push_sp_step: assert property (stk_op == STK_PUSH |=> sp_q == 8'($past(sp_q) + 8'h01))  // [R8]
    else $error("push did not increment pointer");
  a_irq_page_push: assert property (irq_enter && pgen_q && !sw_pg_wr |=>  // [R17]
    page_q == $past(irq_page) && mid_q == $past(page_q) && bot_q == $past(mid_q))
    else $error("page stack push wrong");
  a_ret_page_pop: assert property (irq_return && !irq_enter && pgen_q |=>  // [R18]
    page_q == $past(mid_q) && mid_q == $past(bot_q) && bot_q == 8'h00)
    else $error("page stack pop wrong");
  a_no_auto_page: assert property ((irq_enter || irq_return) && !pgen_q && !sw_pg_wr |=> $stable(page_q))  // [R24]
    else $error("page moved while auto paging off");
  a_fetch_low_bank: assert property (!fetch_addr[15] |-> fetch_phys[16:15] == 2'b00)  // [R22]
    else $error("low fetch not bank zero");
  a_fetch_high_bank: assert property (fetch_addr[15] |-> fetch_phys[16:15] == cbank_q[1:0])  // [R23]
    else $error("high fetch bank mismatch");
  a_sfr_direct_only: assert property (sfr_req.valid |-> !acc.indirect && sfr_req.addr[7])  // [R4]
    else $error("indirect access reached SFR space");
  a_rec_overflow: assert property (  // [R11]
    (stk_op == STK_PUSH || stk_op == STK_INC || stk_op == STK_CALL) && cnt_q == 6'(REC_W) |=> dbg_ovf)
    else $error("record overflow not flagged");
  a_rec_underflow: assert property (  // [R11]
    (stk_op == STK_POP || stk_op == STK_DEC) && cnt_q == 6'h00 ##1 !dbg_clr |=> dbg_unf)
    else $error("record underflow not flagged");
  a_bit_sfr_align: assert property (sfr_req.valid && sfr_req.is_bit |-> sfr_req.addr[2:0] == 3'h0)  // [R12]
    else $error("bit access off nibble 0 or 8");

endmodule : dssp_core

//--- test/dssp_sfr_model.sv
module dssp_sfr_model
  import dssp_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire dssp_sfr_s sfr_req,
  output logic [7:0]     sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h00;

  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i);

  // ----
  // Peripheral registers
  // ----
  always @(posedge clk_sys) begin
    if (sfr_req.valid) begin
      last_q <= mem[sfr_req.addr];
      if (sfr_req.wr) mem[sfr_req.addr] <= sfr_req.wdata;
    end
  end

  // Idle bus shows inverse of last value
  assign sfr_rdata = sfr_req.valid ? mem[sfr_req.addr] : ~last_q;
endmodule : dssp_sfr_model

//--- test/dssp_core_tb.sv
module dssp_core_tb
  import dssp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int RW = 8;
  logic            clk_sys = 1'b0;
  logic            rst = 1'b1;
  dssp_acc_s       acc = '0;
  dssp_stk_e       stk_op = STK_NONE;
  logic [15:0]     stk_wdata = '0;
  logic [15:0]     fetch_addr = '0;
  logic            irq_enter = 1'b0;
  logic            irq_return = 1'b0;
  logic [7:0]      irq_page = '0;
  logic            dbg_clr = 1'b0;
  logic [7:0]      sfr_rdata;
  logic [15:0]     rd_data;
  logic            rd_valid;
  dssp_sfr_s       sfr_req;
  logic [16:0]     fetch_phys;
  logic [7:0]      stack_pointer;
  logic [7:0]      page_select_reg;
  logic [RW-1:0]   stack_record;
  logic            dbg_ovf;
  logic            dbg_unf;
  logic [15:0]     exp_q [$];
  logic [31:0]     seed = 32'ha72e753f;
  int              num_errors = 0;
  int              checked = 0;

  dssp_core #(.REC_W(RW)) dssp_core_i (
    .clk_sys(clk_sys), .rst(rst), .acc(acc), .stk_op(stk_op), .stk_wdata(stk_wdata),
    .irq_enter(irq_enter), .irq_page(irq_page), .irq_return(irq_return), .fetch_addr(fetch_addr),
    .sfr_rdata(sfr_rdata), .dbg_clr(dbg_clr), .rd_data(rd_data), .rd_valid(rd_valid),
    .sfr_req(sfr_req), .fetch_phys(fetch_phys), .stack_pointer(stack_pointer),
    .page_select_reg(page_select_reg), .stack_record(stack_record), .dbg_ovf(dbg_ovf), .dbg_unf(dbg_unf));

  dssp_sfr_model dssp_sfr_model_i (.clk_sys(clk_sys), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));

  always #25 clk_sys = ~clk_sys;

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // Reads note d as the expected byte
  task automatic acc_op(input logic w, input logic ind, input logic bt, input logic sel,
                        input logic [7:0] a, input logic [7:0] d);
    acc <= '{1'b1, w, ind, bt, sel, a, d};
    if (!w) exp_q.push_back({8'h00, d});
    @(negedge clk_sys);
    acc.valid <= 1'b0;
    @(negedge clk_sys);
  endtask : acc_op

  task automatic stk(input dssp_stk_e op, input logic [15:0] wd, input logic rd);
    stk_op <= op;
    stk_wdata <= wd;
    if (rd) exp_q.push_back(wd);
    @(negedge clk_sys);
    stk_op <= STK_NONE;
    @(negedge clk_sys);
  endtask : stk

  task automatic irq(input logic ent, input logic [7:0] p, input logic [7:0] e);
    irq_enter <= ent;
    irq_return <= !ent;
    irq_page <= p;
    @(negedge clk_sys);
    irq_enter <= 1'b0;
    irq_return <= 1'b0;
    chk(page_select_reg, e);
    @(negedge clk_sys);
  endtask : irq

  task automatic fetch(input logic [1:0] b);
    seed = xs(seed);
    fetch_addr <= seed[15:0];
    #1 chk(fetch_phys, {(seed[15] ? b : 2'b00), seed[14:0]});
    @(negedge clk_sys);
  endtask : fetch

  // ----
  // Result watcher
  // ----
  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1) chk(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
  end

  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (10) @(negedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    acc_op(0, 0, 0, 0, SP_ADDR, 8'h07);
    acc_op(0, 0, 0, 0, PGCN_ADDR, 8'h01);
    fetch(2'd1);
    for (int b = 0; b < 4; b++) begin
      acc_op(1, 0, 0, 0, CBANK_ADDR, 8'h10 | 8'(b));
      fetch(2'(b));
      fetch(2'(b));
    end
    seed = xs(seed);
    stk(STK_PUSH, {8'h00, seed[7:0]}, 1'b0);
    chk(stack_pointer, 8'h08);
    acc_op(0, 0, 0, 0, 8'h08, seed[7:0]);
    stk(STK_POP, {8'h00, seed[7:0]}, 1'b1);
    stk(STK_CALL, 16'hc35a, 1'b0);
    chk(stack_record, 32'h3);
    stk(STK_RET, 16'hc35a, 1'b1);
    chk(stack_record, 32'h0);
    repeat (RW + 1) stk(STK_INC, 16'h0, 1'b0);
    chk(dbg_ovf, 1'b1);
    chk(stack_pointer, 8'h10);
    dbg_clr <= 1'b1;
    @(negedge clk_sys);
    dbg_clr <= 1'b0;
    chk(dbg_ovf, 1'b0);
    repeat (RW + 2) stk(STK_DEC, 16'h0, 1'b0);
    chk(dbg_unf, 1'b1);
    acc_op(1, 0, 0, 0, PSW_ADDR, 8'h10);
    acc_op(1, 0, 0, 0, 8'h10, 8'h90);
    acc_op(1, 0, 0, 0, 8'h11, 8'h40);
    seed = xs(seed);
    acc_op(1, 1, 0, 0, 8'h00, seed[7:0]);
    acc_op(1, 1, 0, 1, 8'h00, seed[15:8]);
    acc_op(0, 1, 0, 0, 8'h00, seed[7:0]);
    acc_op(0, 0, 0, 0, 8'h40, seed[15:8]);
    acc_op(0, 1, 0, 1, 8'h00, seed[15:8]);
    acc_op(1, 0, 0, 0, 8'h22, 8'h00);
    acc_op(1, 0, 1, 0, 8'h13, 8'h01);
    acc_op(0, 0, 0, 0, 8'h22, 8'h08);
    acc_op(1, 0, 0, 0, PAGE_ADDR, 8'h0f);
    acc_op(1, 0, 0, 0, BOT_ADDR, 8'h5a);
    acc_op(1, 0, 0, 0, MID_ADDR, 8'h33);
    chk(page_select_reg, 8'h0f);
    irq(1'b1, 8'h02, 8'h02);
    irq(1'b1, 8'h00, 8'h00);
    acc_op(0, 0, 0, 0, MID_ADDR, 8'h02);
    acc_op(0, 0, 0, 0, BOT_ADDR, 8'h0f);
    irq(1'b0, 8'h00, 8'h02);
    acc_op(0, 0, 0, 0, BOT_ADDR, 8'h00);
    irq(1'b0, 8'h00, 8'h0f);
    acc_op(1, 0, 0, 0, PGCN_ADDR, 8'h00);
    irq(1'b1, 8'h03, 8'h0f);
    irq(1'b0, 8'h00, 8'h0f);
    acc_op(0, 0, 0, 0, MID_ADDR, 8'h00);
    acc_op(1, 0, 0, 0, PORT1_ADDR, 8'h21);
    acc_op(0, 0, 0, 0, PORT1_ADDR, 8'h21);
    acc <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 8'h93, 8'h01};
    #1 chk(sfr_req.addr, 8'h90);
    chk(sfr_req.bitpos, 3'h3);
    chk(sfr_req.all_page, 1'b1);
    chk(sfr_req.wdata, 8'h29);
    chk(sfr_req.valid, 1'b1);
    chk(sfr_req.page, 8'h0f);
    chk(sfr_req.page_ok, 1'b1);
    @(negedge clk_sys);
    acc.valid <= 1'b0;
    @(negedge clk_sys);
    acc_op(0, 0, 0, 0, PORT1_ADDR, 8'h29);
    repeat (3) @(negedge clk_sys);
    chk(32'(exp_q.size()), 32'h0);
    report_and_stop();
  end
endmodule : dssp_core_tb
